/* File: src/ckctl_filt_if.sv */
`timescale 1ns/1ns
// Raw pin levels in, debounced levels out
interface ckctl_filt_if #(parameter int W = 2) ();
	logic [W-1:0] raw;
	logic edge_stb;
	logic [W-1:0] clean;
	modport filt(input raw, input edge_stb, output clean);
	modport user(output raw, output edge_stb, input clean);
endinterface

/* File: src/ckctl_pin_filter.sv */
`timescale 1ns/1ns
module ckctl_pin_filter #(
	parameter int W = 2,
	parameter logic [W-1:0] RST = '1
) (
	input wire logic sys_clk, // System clock
	input wire logic nrst, // Async reset, active low
	input wire logic clk_en, // Freezes state when low
	ckctl_filt_if.filt f // Pin levels and sample strobe
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] cand_q;
	logic [W-1:0] clean_q;

	// ********************************************************
	// Synchroniser
	// ********************************************************
	// two-flop sync
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s1_q <= RST;
			s2_q <= RST;
		end else if (clk_en) begin
			s1_q <= f.raw;
			s2_q <= s1_q;
		end
	end

	// ********************************************************
	// Debounce on reference clock edges
	// ********************************************************
	// two-edge agreement
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cand_q <= RST;
			clean_q <= RST;
		end else if (clk_en && f.edge_stb) begin
			cand_q <= s2_q;
			clean_q <= (s2_q & ~(s2_q ^ cand_q)) |
				(clean_q & (s2_q ^ cand_q));
		end
	end

	assign f.clean = clean_q;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	AST_FILT_ON_EDGE: assert property (
		$changed(clean_q) |-> $past(f.edge_stb) && $past(clk_en))
		else $error("Filtered level changed without a sample edge");
	AST_FILT_FROM_SYNC: assert property (
		$changed(clean_q) |-> clean_q == $past(s2_q) &&
			clean_q == $past(cand_q))
		else $error("Filtered level not held over two edges");
endmodule

/* File: src/ckctl_pkg.sv */
package ckctl_pkg;

	// ********************************************************
	// Register map
	// ********************************************************
	localparam logic [7:0] REG_MAP_ADDR = 8'h0A;
	localparam logic [7:0] MAP_RST = 8'h00;
	// Bits 7 and 4 are reserved and never stored
	localparam logic [7:0] MAP_WMASK = 8'h6F;
	localparam int MAP_B_SRC4 = 6;
	localparam int MAP_B_SRC2 = 5;
	localparam int MAP_A_SRC7 = 3;
	localparam int MAP_A_SRC5 = 2;
	localparam int MAP_A_SRC3 = 1;
	localparam int MAP_A_SRC1 = 0;

	// ********************************************************
	// Output groups
	// ********************************************************
	localparam int SRC_N = 8;
	localparam logic [1:0] GRP_CPU = 2'h0;
	localparam logic [1:0] GRP_SRC = 2'h1;
	localparam logic [1:0] GRP_DOT = 2'h2;
	// Filter reset level: pins idle high (pull-ups)
	localparam logic [1:0] PIN_RST = 2'h3;

	// ********************************************************
	// Timing
	// ********************************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int WAKE_MAX_NS = 1800000;
	localparam int WAKE_CYC = WAKE_MAX_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_INIT,
		ST_WAKE,
		ST_RUN,
		ST_PARK,
		ST_OFF
	} ckctl_state_t;

endpackage

/* File: src/ckctl_top.sv */
`timescale 1ns/1ns
module ckctl_top #(
	parameter int N_CPU = 2,
	parameter int WAKE_LIMIT = ckctl_pkg::WAKE_CYC
) (
	input wire logic sys_clk, // 50 MHz system clock
	input wire logic nrst, // Async reset, active low
	input wire logic clk_en, // Freezes all state when low
	input wire logic [7:0] reg_addr, // Register index
	input wire logic [7:0] reg_wdata, // Register write data
	input wire logic reg_wr, // Register write strobe
	output logic [7:0] reg_rdata_q, // Register read data
	input wire logic output_request_a_n, // Request pin A
	input wire logic output_request_b_n, // Request pin B
	input wire logic supply_good_n, // Shared good / power-down pin
	input wire logic cpu_clock_halt_n, // CPU stop, active low
	input wire logic [N_CPU-1:0] cpu_stoppable, // CPU stop config
	input wire logic [2:0] pd_drive_mode, // Per group: 1 = float
	input wire logic pll_locked, // Synthesiser locked
	input wire logic src_ph, // Serial ref clock phase
	input wire logic cpu_ph, // CPU clock phase
	input wire logic dot_ph, // Dot clock phase
	input wire logic se_ph, // Single-ended clock phase
	output logic [ckctl_pkg::SRC_N+N_CPU:0] diff_true_q, // True level
	output logic [ckctl_pkg::SRC_N+N_CPU:0] diff_true_oe_q, // True drive
	output logic [ckctl_pkg::SRC_N+N_CPU:0] diff_comp_q, // Comp level
	output logic [ckctl_pkg::SRC_N+N_CPU:0] diff_comp_oe_q, // Comp drive
	output logic se_out_q, // Single-ended output
	output logic osc_en_q, // Oscillators and synth on
	output logic pd_active_q // Power-down in progress
);
	import ckctl_pkg::*;

	localparam int L = SRC_N + N_CPU + 1;
	localparam int WW = $clog2(WAKE_LIMIT + 1);

	ckctl_state_t st_q, st_d;
	logic [7:0] map_q;
	logic pd_mode_q, se_halt_q;
	logic src_ph_q, cpu_ph_q, dot_ph_q, se_ph_q;
	logic [L-1:0] halted_q;
	logic [WW-1:0] wake_cnt_q;
	logic [L-1:0] lane_ph, lane_prev, lane_hi, lane_req, want, pick;
	logic [SRC_N-1:0] src_req;
	logic pd_clean, cpu_halt, pd_halt, in_wake, go_run;

	// ********************************************************
	// Helpers
	// ********************************************************
	function automatic logic [SRC_N-1:0] mask_a(input logic [7:0] m);
		mask_a = {m[MAP_A_SRC7], 1'b0, m[MAP_A_SRC5], 1'b0,
			m[MAP_A_SRC3], 1'b0, m[MAP_A_SRC1], 1'b0};
	endfunction

	function automatic logic [SRC_N-1:0] mask_b(input logic [7:0] m);
		mask_b = {3'h0, m[MAP_B_SRC4], 1'b0, m[MAP_B_SRC2], 2'h0};
	endfunction

	function automatic logic [1:0] lane_grp(input int l);
		if (l < SRC_N) begin
			lane_grp = GRP_SRC;
		end else if (l < SRC_N + N_CPU) begin
			lane_grp = GRP_CPU;
		end else begin
			lane_grp = GRP_DOT;
		end
	endfunction

	// ********************************************************
	// Pin filters
	// ********************************************************
	ckctl_filt_if #(.W(2)) req_if ();
	ckctl_filt_if #(.W(2)) pin_if ();

	// Request pins sample on serial comp rising edge
	assign req_if.raw = {output_request_b_n, output_request_a_n};
	assign req_if.edge_stb = src_ph_q & ~src_ph;
	// Shared pin and CPU halt sample on CPU comp rising edge
	assign pin_if.raw = {cpu_clock_halt_n, supply_good_n};
	assign pin_if.edge_stb = cpu_ph_q & ~cpu_ph;

	ckctl_pin_filter #(.W(2), .RST(PIN_RST)) u_req_filt (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.clk_en(clk_en),
		.f(req_if.filt)
	);

	ckctl_pin_filter #(.W(2), .RST(PIN_RST)) u_pin_filt (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.clk_en(clk_en),
		.f(pin_if.filt)
	);

	// ********************************************************
	// Register
	// ********************************************************
	// reserved bits dropped
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			map_q <= MAP_RST;
		end else if (clk_en && reg_wr && reg_addr == REG_MAP_ADDR) begin
			map_q <= reg_wdata & MAP_WMASK;
		end
	end

	// Read data registered; unmapped indices read zero
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata_q <= 8'h00;
		end else if (clk_en) begin
			if (reg_addr == REG_MAP_ADDR) begin
				reg_rdata_q <= map_q;
			end else begin
				reg_rdata_q <= 8'h00;
			end
		end
	end

	// ********************************************************
	// Lane decisions
	// ********************************************************
	// either mapped pin stops a lane
	assign src_req = (mask_a(map_q) & {SRC_N{req_if.clean[0]}}) |
		(mask_b(map_q) & {SRC_N{req_if.clean[1]}});
	// power down only after supply good seen
	assign pd_clean = pd_mode_q & pin_if.clean[0];
	assign cpu_halt = ~pin_if.clean[1];
	assign pd_halt = (st_q == ST_PARK) || (st_q == ST_OFF);
	assign in_wake = (st_q == ST_INIT) || (st_q == ST_WAKE);
	// only stoppable CPU lanes, others run on
	assign lane_req = {1'b0, {N_CPU{cpu_halt}} & cpu_stoppable, src_req};
	assign lane_ph = {dot_ph, {N_CPU{cpu_ph}}, {SRC_N{src_ph}}};
	assign lane_prev = {dot_ph_q, {N_CPU{cpu_ph_q}}, {SRC_N{src_ph_q}}};
	// Lanes parking high switch on a rising phase, others on falling
	assign lane_hi = {L{pd_halt}} | {{(N_CPU + 1){1'b1}}, {SRC_N{1'b0}}};
	assign want = {L{pd_halt}} | ({L{st_q == ST_RUN}} & lane_req);
	assign pick = (lane_ph ^ lane_prev) & ~(lane_ph ^ lane_hi);
	// release on lock, or at the wake limit at the latest
	assign go_run = (st_q == ST_WAKE) && !pd_clean &&
		(pll_locked || wake_cnt_q == WW'(WAKE_LIMIT - 1));

	// ********************************************************
	// Power sequence
	// ********************************************************
	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_INIT: if (pd_mode_q) st_d = ST_WAKE;
			ST_WAKE: begin
				if (pd_clean) begin
					st_d = ST_PARK;
				end else if (go_run) begin
					st_d = ST_RUN;
				end
			end
			ST_RUN: if (pd_clean) st_d = ST_PARK;
			// oscillators stay on until all parked
			ST_PARK: if (&halted_q && se_halt_q) st_d = ST_OFF;
			ST_OFF: if (!pd_clean) st_d = ST_WAKE;
			default: st_d = ST_INIT;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= ST_INIT;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	// pin turns into power-down for good
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pd_mode_q <= 1'b0;
		end else if (clk_en && !pin_if.clean[0]) begin
			pd_mode_q <= 1'b1;
		end
	end

	// Counter bounds the wait for lock
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wake_cnt_q <= '0;
		end else if (clk_en) begin
			wake_cnt_q <= (st_q == ST_WAKE) ? wake_cnt_q + 1'b1 : '0;
		end
	end

	// Phase history for edge detection
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			src_ph_q <= 1'b0;
			cpu_ph_q <= 1'b0;
			dot_ph_q <= 1'b0;
			se_ph_q <= 1'b0;
		end else if (clk_en) begin
			src_ph_q <= src_ph;
			cpu_ph_q <= cpu_ph;
			dot_ph_q <= dot_ph;
			se_ph_q <= se_ph;
		end
	end

	// ********************************************************
	// Stop and resume
	// ********************************************************
	// switch at a lane edge, no runt pulse; go_run clears, wake sets all at once
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			halted_q <= '1;
		end else if (clk_en) begin
			if (go_run) begin
				halted_q <= '0;
			end else if (in_wake) begin
				halted_q <= '1;
			end else begin
				halted_q <= (halted_q & ~pick) | (want & pick);
			end
		end
	end

	// single-ended held low from its next falling edge
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			se_halt_q <= 1'b1;
		end else if (clk_en) begin
			if (go_run) begin
				se_halt_q <= 1'b0;
			end else if (in_wake) begin
				se_halt_q <= 1'b1;
			end else if (se_ph_q && !se_ph) begin
				se_halt_q <= pd_halt;
			end
		end
	end

	// ********************************************************
	// Output drive
	// ********************************************************
	// Registered pins; one cycle behind the phase inputs
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			diff_true_q <= '0;
			diff_true_oe_q <= '0;
			diff_comp_q <= '0;
			diff_comp_oe_q <= '0;
		end else if (clk_en) begin
			for (int l = 0; l < L; l++) begin
				diff_comp_q[l] <= 1'b0;
				diff_comp_oe_q[l] <= 1'b0;
				if (in_wake) begin
					// true line held high until release
					diff_true_q[l] <= 1'b1;
					diff_true_oe_q[l] <= 1'b1;
				end else if (!halted_q[l]) begin
					diff_true_q[l] <= lane_ph[l];
					diff_true_oe_q[l] <= 1'b1;
					diff_comp_q[l] <= ~lane_ph[l];
					diff_comp_oe_q[l] <= 1'b1;
				end else if (pd_halt) begin
					// mode bit picks high or float
					diff_true_q[l] <= 1'b1;
					diff_true_oe_q[l] <= ~pd_drive_mode[lane_grp(l)];
				end else if (lane_grp(l) == GRP_SRC) begin
					diff_true_q[l] <= 1'b0;
					diff_true_oe_q[l] <= 1'b0;
				end else begin
					// CPU park: true high, comp floats
					diff_true_q[l] <= 1'b1;
					diff_true_oe_q[l] <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			se_out_q <= 1'b0;
			osc_en_q <= 1'b1;
			pd_active_q <= 1'b0;
		end else if (clk_en) begin
			se_out_q <= se_ph & ~se_halt_q;
			osc_en_q <= (st_d != ST_OFF);
			pd_active_q <= (st_d == ST_PARK) || (st_d == ST_OFF);
		end
	end

	// ********************************************************
	// Checks
	// ********************************************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	AST_RSVD_ZERO: assert property (
		!reg_rdata_q[7] && !reg_rdata_q[4])
		else $error("Reserved map bits read as one");
	AST_SRC_STOP_LOW: assert property (
		clk_en && st_q == ST_RUN && halted_q[1] ##1 clk_en |->
			!diff_true_oe_q[1] && !diff_comp_oe_q[1] && !diff_true_q[1])
		else $error("Stopped serial output still driven");
	AST_SRC_TOGETHER: assert property (
		st_q == ST_RUN && !want[3] && !want[5] && pick[3] |=>
			halted_q[3] == halted_q[5] || !clk_en)
		else $error("Serial outputs did not resume together");
	AST_PD_MODE_HOLD: assert property (
		pd_mode_q |=> pd_mode_q)
		else $error("Power-down function reverted");
	AST_OSC_AFTER_PARK: assert property (
		$fell(osc_en_q) |-> $past(&halted_q) && $past(se_halt_q))
		else $error("Oscillators stopped before outputs parked");
	AST_PARK_MODE: assert property (
		st_q == ST_OFF && $past(st_q) == ST_OFF && $stable(pd_drive_mode)
			&& $past(clk_en) |-> !diff_comp_oe_q[L-1] &&
			diff_true_oe_q[L-1] == !pd_drive_mode[GRP_DOT])
		else $error("Parked dot lane ignores drive mode");
	AST_WAKE_HIGH: assert property (
		st_q == ST_WAKE && $past(st_q) == ST_WAKE && $past(clk_en) |->
			&diff_true_oe_q && &diff_true_q)
		else $error("True lines not driven high in wake");
	AST_WAKE_BOUND: assert property (
		st_q == ST_WAKE |-> wake_cnt_q < WW'(WAKE_LIMIT))
		else $error("Wake exceeded the stable clock limit");
	AST_RELEASE_ALL: assert property (
		go_run && clk_en |=> halted_q == '0 && !se_halt_q)
		else $error("Outputs not released together");
	AST_CPU_PARK: assert property (
		clk_en && st_q == ST_RUN && halted_q[SRC_N] ##1 clk_en |->
			diff_true_q[SRC_N] && diff_true_oe_q[SRC_N] &&
			!diff_comp_oe_q[SRC_N])
		else $error("Halted CPU lane not parked high");
	AST_CPU_ONLY: assert property (
		st_q == ST_RUN && clk_en |=> !halted_q[L-1] || st_q != ST_RUN)
		else $error("Dot lane stopped by CPU halt");

	COV_SRC_STOP: cover property (st_q == ST_RUN && $rose(halted_q[1]));
	COV_CPU_STOP: cover property (st_q == ST_RUN && $rose(halted_q[SRC_N]));
	COV_PD_CYCLE: cover property (st_q == ST_OFF ##[1:200] st_q == ST_RUN);
endmodule

/* File: tb/ckctl_chipset.sv */
`timescale 1ns/1ns
// ********************************************************
// Chipset side: request pins and generated clock phases
// ********************************************************
module ckctl_chipset (
	input wire logic sys_clk, // System clock
	input wire logic nrst, // Async reset, active low
	input wire logic [3:0] want, // Asked: pd, halt_n, b_n, a_n
	output logic [3:0] pins, // Pin levels, async to sys_clk
	output logic [3:0] ph // Phases: se, dot, cpu, src
);
	logic [1:0] div_q;
	// Pins idle high on their pull-ups until first asked
	initial pins = 4'hF;
	// pins move mid cycle, all four after the same 7 ns delay
	always @(want) begin
		pins <= #7 want;
	end
	// Phases toggle every two cycles, so a period is four cycles
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			div_q <= 2'h0;
			ph <= 4'h0;
		end else begin
			div_q <= div_q + 2'h1;
			if (div_q[0]) begin
				ph <= ~ph;
			end
		end
	end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ns
module tb;
	import ckctl_pkg::*;
	localparam int WL = 64;
	logic sys_clk, nrst, reg_wr, pll_locked, ce;
	logic se_out_q, osc_en_q, pd_active_q;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_q, m, d, e8;
	logic [1:0] cs;
	logic [2:0] md;
	logic [3:0] want, pins, ph;
	logic [10:0] dt, dto, dc, dco;
	logic [31:0] seed;
	int n_fail, checked, cyc, i, k;

	// ********************************************************
	// Clock, design and chipset model
	// ********************************************************
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	ckctl_top #(.N_CPU(2), .WAKE_LIMIT(WL)) u_ckctl_top (
		.sys_clk(sys_clk), .nrst(nrst), .clk_en(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rdata_q(reg_rdata_q), .output_request_a_n(pins[0]),
		.output_request_b_n(pins[1]), .cpu_clock_halt_n(pins[2]),
		.supply_good_n(pins[3]), .cpu_stoppable(cs),
		.pd_drive_mode(md), .pll_locked(pll_locked), .src_ph(ph[0]),
		.cpu_ph(ph[1]), .dot_ph(ph[2]), .se_ph(ph[3]),
		.diff_true_q(dt), .diff_true_oe_q(dto), .diff_comp_q(dc),
		.diff_comp_oe_q(dco), .se_out_q(se_out_q),
		.osc_en_q(osc_en_q), .pd_active_q(pd_active_q));
	ckctl_chipset u_ckctl_chipset (.sys_clk(sys_clk), .nrst(nrst),
		.want(want), .pins(pins), .ph(ph));

	// ********************************************************
	// Helpers
	// ********************************************************
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Serial lanes that a request should hold stopped
	function automatic logic [7:0] stop_mask(logic [7:0] mp, logic a,
		logic b);
		stop_mask = 8'h00;
		stop_mask[7] = mp[3] & a;
		stop_mask[5] = mp[2] & a;
		stop_mask[3] = mp[1] & a;
		stop_mask[1] = mp[0] & a;
		stop_mask[4] = mp[6] & b;
		stop_mask[2] = mp[5] & b;
	endfunction
	// True lines still driven once parked; dot, CPU, serial groups
	function automatic logic [10:0] park_oe(logic [2:0] mo);
		return {~mo[2], {2{~mo[0]}}, {8{~mo[1]}}};
	endfunction
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data is registered one edge behind the address
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		tick(1);
		v = reg_rdata_q;
	endtask
	// Bounded wait for every lane running on both lines
	task automatic wait_run(input int lim);
		k = 0;
		while (k < lim && (&{dco, dto}) !== 1'b1) begin
			tick(1);
			k++;
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// A hang is cut short well past the expected run length
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 6000) begin
			n_fail++;
			wrap_up();
		end
	end

	// ********************************************************
	// Main sequence
	// ********************************************************
	initial begin
		seed = 84;
		n_fail = 0;
		checked = 0;
		cyc = 0;
		nrst = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		pll_locked = 1'b0;
		ce = 1'b1;
		cs = 2'h0;
		md = 3'h0;
		want = 4'hC;
		repeat (4) @(posedge sys_clk);
		nrst <= 1'b1;
		tick(10);
		chk("osc_en", 1, osc_en_q);
		chk("pd_active", 0, pd_active_q);
		chk("init_comp_oe", 0, dco);
		rd(REG_MAP_ADDR, d);
		chk("map_reset", MAP_RST, d);
		@(posedge sys_clk);
		want[3] <= 1'b0;
		pll_locked <= 1'b1;
		wait_run(60);
		chk("all_run", 16'h07FF, dco & dto);
		$display("test power up done");
		for (i = 0; i < 6; i++) begin
			d = (i == 0) ? 8'hFF : 8'(xs());
			wr(REG_MAP_ADDR, d);
			rd(REG_MAP_ADDR, m);
			chk("map", d & 8'h6F, m);
		end
		wr(8'h0B, 8'hFF);
		rd(8'h0B, d);
		chk("unmapped", 0, d);
		rd(REG_MAP_ADDR, d);
		chk("map_kept", m, d);
		// Write while frozen must not land
		ce <= 1'b0;
		wr(REG_MAP_ADDR, m ^ 8'h6F);
		ce <= 1'b1;
		rd(REG_MAP_ADDR, d);
		chk("frozen_map", m, d);
		$display("test register done");
		for (i = 0; i < 5; i++) begin
			m = (i == 0) ? MAP_WMASK : (8'(xs()) & MAP_WMASK);
			k = (i == 0) ? 3 : xs();
			wr(REG_MAP_ADDR, m);
			@(posedge sys_clk);
			want[1:0] <= k[1:0];
			tick(28);
			e8 = stop_mask(m, want[0], want[1]);
			chk("src_comp_oe", e8 ^ 8'hFF, dco[7:0]);
			chk("src_true_oe", e8 ^ 8'hFF, dto[7:0]);
			chk("src_true_low", 0, dt[7:0] & e8);
			chk("src_comp_low", 0, dc[7:0] & e8);
			@(posedge sys_clk);
			want[1:0] <= 2'h0;
			tick(28);
			chk("src_resume", 8'hFF, dco[7:0] & dto[7:0]);
		end
		wr(REG_MAP_ADDR, 8'h0F);
		@(posedge sys_clk);
		want[0] <= 1'b1;
		@(posedge sys_clk);
		want[0] <= 1'b0;
		tick(28);
		chk("short_pulse", 8'hFF, dco[7:0]);
		$display("test request pins done");
		for (i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			cs <= (i == 0) ? 2'h3 : 2'(xs());
			want[2] <= 1'b0;
			tick(24);
			repeat (2) begin
				chk("cpu_comp_oe", cs ^ 2'h3, dco[9:8]);
				chk("cpu_true_oe", 3, dto[9:8]);
				chk("cpu_true_high", cs, dt[9:8] & cs);
				chk("cpu_comp_low", 0, dc[9:8] & cs);
				chk("src_live", 8'hFF, dco[7:0]);
				tick(2);
			end
			@(posedge sys_clk);
			want[2] <= 1'b1;
			tick(20);
			chk("cpu_resume", 3, dco[9:8]);
		end
		$display("test cpu halt done");
		for (i = 0; i < 3; i++) begin
			@(posedge sys_clk);
			md <= (i == 0) ? 3'h5 : 3'(xs());
			want[3] <= 1'b1;
			tick(1);
			k = 0;
			while (k < 60 && osc_en_q !== 1'b0) begin
				tick(1);
				k++;
			end
			chk("osc_off", 0, osc_en_q);
			chk("pd_active", 1, pd_active_q);
			chk("se_low", 0, se_out_q);
			chk("park_comp_oe", 0, dco);
			chk("park_comp", 0, dc);
			chk("park_true_oe", park_oe(md), dto);
			chk("park_true", park_oe(md), dt & park_oe(md));
			@(posedge sys_clk);
			pll_locked <= 1'b0;
			want[3] <= 1'b0;
			tick(20);
			chk("wake_true_oe", 16'h07FF, dto);
			chk("wake_true", 16'h07FF, dt);
			wait_run(WL + 20);
			chk("wake_run", 16'h07FF, dco & dto);
			chk("wake_osc", 1, osc_en_q);
			@(posedge sys_clk);
			pll_locked <= 1'b1;
		end
		$display("test power down done");
		wrap_up();
	end
endmodule
